/* src/mx_exec.sv */
/*
 * mx_exec: execution unit for the miscellaneous, add and AND instructions of
 * an 8-bit core, with its working register, flags, data memory, watchdog and
 * halt state, reached over an AHB-Lite slave with zero wait states.
 * Assumes one 100 MHz clock and a single master doing single word transfers.
 */
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
module mx_exec #(
    parameter bit WIDE_ADDR = 1'b1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // power state
    output logic powerdown
);
    logic [7:0] dmem_q [256];
    logic [7:0] wreg_q;
    logic [3:0] aflag_q;
    logic to_q, pd_q;
    wire [5:0] status_q = {to_q, pd_q, aflag_q};
    logic [7:0] pcl_q;
    logic [7:0] wdt_q;
    logic [3:0] wdt_pre_q;
    logic [1:0] phase_q;
    logic [7:0] cycles_q;
    logic [7:0] remain_q;
    logic halted_q, skipped_q, pre1_q, pre2_q, wdt_expire;
    mx_exec_pkg::mx_state_t state_q;
    mx_exec_pkg::mx_instr_t instr_q;
    logic dp_wr_q;
    logic [7:0] dp_addr_q;
    logic [31:0] hrdata_q;
    logic [7:0] dp_mem_addr_q;
    localparam logic [7:0] CLKS2 = mx_exec_pkg::CLKS_PER_ICYC + mx_exec_pkg::CLKS_PER_ICYC;

    wire addr_ph = hsel & htrans[1] & hready;
    wire wr_en = dp_wr_q;
    wire start = wr_en && (dp_addr_q == mx_exec_pkg::REG_INSTR) && (state_q == mx_exec_pkg::MX_IDLE) && !halted_q;
    wire cyc_en = (phase_q == mx_exec_pkg::PHASE_LAST);

    // incoming instruction and its operand
    mx_exec_pkg::mx_instr_t ins;
    logic [7:0] m_addr, m_val, res;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic cin, use_carry, to_mem, to_wreg, add_op, and_op, pcl_hit, skip_hit;

    // operand address limited to the variant's field width
    function automatic logic [7:0] mask_addr(input logic [7:0] a);
        return a & (WIDE_ADDR ? mx_exec_pkg::ADDR_MASK_LARGE : mx_exec_pkg::ADDR_MASK_SMALL);
    endfunction

    // memory read with the program counter low byte aliased in
    function automatic logic [7:0] mem_rd(input logic [7:0] a);
        return (a == mx_exec_pkg::PCL_MEM_ADDR) ? pcl_q : dmem_q[a];
    endfunction

    always_comb begin
        ins = mx_exec_pkg::mx_instr_t'(hwdata[20:0]);
        m_addr = mask_addr(ins.addr);
        m_val = mem_rd(m_addr);
        use_carry = (ins.opcode == mx_exec_pkg::OP_ADC_AM) || (ins.opcode == mx_exec_pkg::OP_ADC_M);
        cin = use_carry & status_q[mx_exec_pkg::ST_CARRY];
        add_op = 1'b0;
        and_op = 1'b0;
        to_mem = 1'b0;
        to_wreg = 1'b0;
        res = m_val;
        sum9 = 9'h000;
        sum5 = 5'h00;
        case (ins.opcode)
            mx_exec_pkg::OP_CLR_M: begin
                res = 8'h00;
                to_mem = 1'b1;
            end
            mx_exec_pkg::OP_SET_M: begin
                res = 8'hFF;
                to_mem = 1'b1;
            end
            mx_exec_pkg::OP_SWAP_M: begin
                res = {m_val[3:0], m_val[7:4]};
                to_mem = 1'b1;
            end
            mx_exec_pkg::OP_SWAP_A: begin
                res = {m_val[3:0], m_val[7:4]};
                to_wreg = 1'b1;
            end
            mx_exec_pkg::OP_ADD_AM, mx_exec_pkg::OP_ADC_AM, mx_exec_pkg::OP_ADD_AX: begin
                add_op = 1'b1;
                to_wreg = 1'b1;
            end
            mx_exec_pkg::OP_ADD_M, mx_exec_pkg::OP_ADC_M: begin
                add_op = 1'b1;
                to_mem = 1'b1;
            end
            mx_exec_pkg::OP_AND_AM: begin
                res = wreg_q & m_val;
                and_op = 1'b1;
                to_wreg = 1'b1;
            end
            mx_exec_pkg::OP_AND_AX: begin
                res = wreg_q & ins.imm;
                and_op = 1'b1;
                to_wreg = 1'b1;
            end
            mx_exec_pkg::OP_AND_M: begin
                res = m_val & wreg_q;
                and_op = 1'b1;
                to_mem = 1'b1;
            end
            default: begin
                res = m_val;
            end
        endcase
        if (add_op) begin
            if (ins.opcode == mx_exec_pkg::OP_ADD_AX) begin
                sum9 = {1'b0, wreg_q} + {1'b0, ins.imm};
                sum5 = {1'b0, wreg_q[3:0]} + {1'b0, ins.imm[3:0]};
            end else begin
                sum9 = {1'b0, wreg_q} + {1'b0, m_val} + {8'h00, cin};
                sum5 = {1'b0, wreg_q[3:0]} + {1'b0, m_val[3:0]} + {4'h0, cin};
            end
            res = sum9[7:0];
        end
        pcl_hit = to_mem && (m_addr == mx_exec_pkg::PCL_MEM_ADDR);
        skip_hit = (ins.opcode == mx_exec_pkg::OP_SKIP_Z) && (m_val == 8'h00);
    end

    // ahb address phase: latch writes, prepare read data for the data phase
    function automatic logic [31:0] reg_rd(input logic [7:0] a);
        case (a)
            mx_exec_pkg::REG_INSTR: return {11'h000, instr_q};
            mx_exec_pkg::REG_WREG: return {24'h000000, wreg_q};
            mx_exec_pkg::REG_STATUS: return {26'h0000000, status_q};
            mx_exec_pkg::REG_CTRL: return {28'h0000000, pre1_q, skipped_q, halted_q, state_q == mx_exec_pkg::MX_RUN};
            mx_exec_pkg::REG_MEM_ADDR: return {24'h000000, dp_mem_addr_q};
            mx_exec_pkg::REG_MEM_DATA: return {24'h000000, mem_rd(dp_mem_addr_q)};
            mx_exec_pkg::REG_PCL: return {24'h000000, pcl_q};
            mx_exec_pkg::REG_CYCLES: return {24'h000000, cycles_q};
            mx_exec_pkg::REG_WDT: return {20'h00000, wdt_pre_q, wdt_q};
            default: return 32'h00000000;
        endcase
    endfunction

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dp_wr_q <= 1'b0;
            dp_addr_q <= 8'h00;
            hrdata_q <= 32'h00000000;
        end else begin
            dp_wr_q <= addr_ph & hwrite;
            if (addr_ph) begin
                dp_addr_q <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFC;
                hrdata_q <= (haddr[31:8] == 24'h000000) ? reg_rd(haddr[7:0]) : 32'h00000000;
            end
        end
    end

    // zero wait states, always okay
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
    assign hrdata = hrdata_q;

    // instruction cycle divider, realigned on each start
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= 2'h0;
        end else if (start) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // execution sequencer: remaining instruction cycles, base zero
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= mx_exec_pkg::MX_IDLE;
            remain_q <= 8'h00;
            cycles_q <= 8'h00;
            skipped_q <= 1'b0;
            instr_q <= '0;
        end else begin
            case (state_q)
                mx_exec_pkg::MX_IDLE: begin
                    if (start) begin
                        state_q <= mx_exec_pkg::MX_RUN;
                        instr_q <= ins;
                        skipped_q <= skip_hit;
                        remain_q <= (pcl_hit || skip_hit) ? 8'h01 : 8'h00;
                        cycles_q <= (pcl_hit || skip_hit) ? CLKS2 : mx_exec_pkg::CLKS_PER_ICYC;
                    end
                end
                mx_exec_pkg::MX_RUN: begin
                    if (cyc_en) begin
                        if (remain_q == 8'h00) begin
                            state_q <= mx_exec_pkg::MX_IDLE;
                        end else begin
                            remain_q <= remain_q - 8'h01;
                        end
                    end
                end
                default: begin
                    state_q <= mx_exec_pkg::MX_IDLE;
                end
            endcase
        end
    end

    // working register, results land at start, software may load it at any time, busy or idle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wreg_q <= mx_exec_pkg::WREG_RST;
        end else if (start && to_wreg) begin
            wreg_q <= res;
        end else if (wr_en && dp_addr_q == mx_exec_pkg::REG_WREG) begin
            wreg_q <= hwdata[7:0];
        end
    end

    // data memory holds no reset; the pcl alias is a separate register
    always_ff @(posedge core_clk) begin
        if (start && to_mem && !pcl_hit) begin
            dmem_q[m_addr] <= res;
        end else if (wr_en && dp_addr_q == mx_exec_pkg::REG_MEM_DATA && dp_mem_addr_q != mx_exec_pkg::PCL_MEM_ADDR) begin
            dmem_q[dp_mem_addr_q] <= hwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pcl_q <= mx_exec_pkg::PCL_RST;
            dp_mem_addr_q <= 8'h00;
        end else begin
            if (start && pcl_hit) begin
                pcl_q <= res;
            end else if (wr_en && (dp_addr_q == mx_exec_pkg::REG_PCL || (dp_addr_q == mx_exec_pkg::REG_MEM_DATA
                    && dp_mem_addr_q == mx_exec_pkg::PCL_MEM_ADDR))) begin
                pcl_q <= hwdata[7:0];
            end
            if (wr_en && dp_addr_q == mx_exec_pkg::REG_MEM_ADDR) begin
                dp_mem_addr_q <= mask_addr(hwdata[7:0]);
            end
        end
    end

    // arithmetic flags; idle, clear, set and swap leave them alone
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aflag_q <= mx_exec_pkg::STATUS_RST[3:0];
        end else if (start && add_op) begin
            aflag_q[mx_exec_pkg::ST_CARRY] <= sum9[8];
            aflag_q[mx_exec_pkg::ST_HALF] <= sum5[4];
            aflag_q[mx_exec_pkg::ST_ZERO] <= (sum9[7:0] == 8'h00);
            aflag_q[mx_exec_pkg::ST_WRAP] <= (wreg_q[7] == (ins.opcode == mx_exec_pkg::OP_ADD_AX ? ins.imm[7] : m_val[7]))
                && (sum9[7] != wreg_q[7]);
        end else if (start && and_op) begin
            aflag_q[mx_exec_pkg::ST_ZERO] <= (res == 8'h00);
        end else if (wr_en && dp_addr_q == mx_exec_pkg::REG_STATUS) begin
            aflag_q <= hwdata[3:0];
        end
    end

    wire do_wdt_clr = start && (ins.opcode == mx_exec_pkg::OP_WDT_CLR
        || (ins.opcode == mx_exec_pkg::OP_WDT_PRE2 && pre1_q)
        || (ins.opcode == mx_exec_pkg::OP_WDT_PRE1 && pre2_q));
    wire do_halt = start && ins.opcode == mx_exec_pkg::OP_HALT;
    assign wdt_expire = cyc_en && wdt_pre_q == mx_exec_pkg::WDT_PRESCALE_LAST && wdt_q == 8'hFF;

    // pre-clear pair: either order, the second one completes the clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pre1_q <= 1'b0;
            pre2_q <= 1'b0;
        end else if (do_wdt_clr || do_halt) begin
            pre1_q <= 1'b0;
            pre2_q <= 1'b0;
        end else if (start && ins.opcode == mx_exec_pkg::OP_WDT_PRE1) begin
            pre1_q <= 1'b1;
        end else if (start && ins.opcode == mx_exec_pkg::OP_WDT_PRE2) begin
            pre2_q <= 1'b1;
        end
    end

    // watchdog counter and prescaler; counts instruction cycles, also in halt so expiry can wake
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wdt_q <= 8'h00;
            wdt_pre_q <= 4'h0;
        end else if (do_wdt_clr || do_halt) begin
            wdt_q <= 8'h00;
            wdt_pre_q <= 4'h0;
        end else if (cyc_en) begin
            wdt_pre_q <= wdt_pre_q + 4'h1;
            if (wdt_pre_q == mx_exec_pkg::WDT_PRESCALE_LAST) begin
                wdt_q <= wdt_q + 8'h01;
            end
        end
    end

    // expired and power-down flags; expiry sets the expired flag and wins over any clear of it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            to_q <= mx_exec_pkg::STATUS_RST[mx_exec_pkg::ST_TO];
            pd_q <= mx_exec_pkg::STATUS_RST[mx_exec_pkg::ST_PD];
            halted_q <= 1'b0;
        end else begin
            if (wdt_expire) begin
                to_q <= 1'b1;
            end else if (do_wdt_clr || do_halt) begin
                to_q <= 1'b0;
            end
            if (do_halt) begin
                pd_q <= 1'b1;
            end else if (do_wdt_clr) begin
                pd_q <= 1'b0;
            end
            if (do_halt) begin
                halted_q <= 1'b1;
            end else if (wdt_expire || (wr_en && dp_addr_q == mx_exec_pkg::REG_CTRL && hwdata[mx_exec_pkg::CT_WAKE])) begin
                halted_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            powerdown <= 1'b0;
        end else begin
            powerdown <= halted_q;
        end
    end
endmodule // mx_exec

/* src/mx_exec_pkg.sv */
/*
 * mx_exec_pkg: register map, opcodes, field layout, reset values and timing
 * constants of the miscellaneous/add/AND execution unit.
 * Assumes a single 100 MHz core clock and a 32-bit AHB-Lite register bus.
 */
package mx_exec_pkg;
    // register byte addresses
    localparam logic [7:0] REG_INSTR = 8'h00;
    localparam logic [7:0] REG_WREG = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam logic [7:0] REG_MEM_ADDR = 8'h10;
    localparam logic [7:0] REG_MEM_DATA = 8'h14;
    localparam logic [7:0] REG_PCL = 8'h18;
    localparam logic [7:0] REG_CYCLES = 8'h1C;
    localparam logic [7:0] REG_WDT = 8'h20;

    // data memory location that aliases the program counter low byte
    localparam logic [7:0] PCL_MEM_ADDR = 8'h06;
    localparam logic [7:0] ADDR_MASK_SMALL = 8'h7F;
    localparam logic [7:0] ADDR_MASK_LARGE = 8'hFF;

    // status bit positions
    localparam int ST_CARRY = 0;
    localparam int ST_HALF = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_WRAP = 3;
    localparam int ST_PD = 4;
    localparam int ST_TO = 5;
    // ctrl bit positions
    localparam int CT_WAKE = 0;
    localparam int CT_BUSY = 0;
    localparam int CT_HALTED = 1;
    localparam int CT_SKIPPED = 2;
    localparam int CT_PRE1 = 3;

    // opcodes, field [20:16] of REG_INSTR
    localparam logic [4:0] OP_IDLE = 5'h00;
    localparam logic [4:0] OP_CLR_M = 5'h01;
    localparam logic [4:0] OP_SET_M = 5'h02;
    localparam logic [4:0] OP_WDT_CLR = 5'h03;
    localparam logic [4:0] OP_WDT_PRE1 = 5'h04;
    localparam logic [4:0] OP_WDT_PRE2 = 5'h05;
    localparam logic [4:0] OP_SWAP_M = 5'h06;
    localparam logic [4:0] OP_SWAP_A = 5'h07;
    localparam logic [4:0] OP_HALT = 5'h08;
    localparam logic [4:0] OP_ADD_AM = 5'h09;
    localparam logic [4:0] OP_ADD_AX = 5'h0A;
    localparam logic [4:0] OP_ADC_AM = 5'h0B;
    localparam logic [4:0] OP_ADD_M = 5'h0C;
    localparam logic [4:0] OP_ADC_M = 5'h0D;
    localparam logic [4:0] OP_AND_AM = 5'h0E;
    localparam logic [4:0] OP_AND_AX = 5'h0F;
    localparam logic [4:0] OP_AND_M = 5'h10;
    localparam logic [4:0] OP_SKIP_Z = 5'h11;

    // timing: one instruction cycle is four system clocks
    localparam int CLK_MHZ = 100;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [7:0] CLKS_PER_ICYC = 8'h04;
    localparam logic [3:0] WDT_PRESCALE_LAST = 4'hF;

    // reset values
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [5:0] STATUS_RST = 6'h00;
    localparam logic [7:0] PCL_RST = 8'h00;

    typedef struct packed {
        logic [4:0] opcode;
        logic [7:0] imm;
        logic [7:0] addr;
    } mx_instr_t;

    typedef enum logic {MX_IDLE, MX_RUN} mx_state_t;
endpackage

/* verification/mx_ahb_host.sv */
/* mx_ahb_host: AHB-Lite master model for single word transfers.
   Assumes hready is the slave's hreadyout; the bench calls xfer. */
`timescale 1ns/1ns
module mx_ahb_host (
    // clock
    input wire logic core_clk,
    // master side
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'hA5A5A5A5;
    end
    // data line flips once released, so a stale word never passes for fresh data
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        if (w) hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
        hwdata <= ~hwdata;
    endtask
endmodule // mx_ahb_host

/* verification/mx_exec_assertions.sv */
/* mx_exec_assertions: port-level checker for mx_exec, bound into it.
   Assumes hreadyout loops back to hready and the master does single transfers. */
`timescale 1ns/1ns
module mx_exec_assertions (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // power state
    input wire logic powerdown
);
    logic acc, instr_c, ctrl_c, wr_q, rd_q;
    logic [7:0] adr_q;
    logic [3:0] gap_q;
    logic [4:0] op_q;
    assign acc = hsel && htrans[1] && hready;
    assign instr_c = wr_q && adr_q == mx_exec_pkg::REG_INSTR;
    assign ctrl_c = wr_q && adr_q == mx_exec_pkg::REG_CTRL;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            adr_q <= 8'h00;
        end else begin
            wr_q <= acc && hwrite;
            rd_q <= acc && !hwrite;
            if (acc) adr_q <= haddr[7:0];
        end
    end
    // gap since the last instruction: busy never outlasts 8 clocks, so 10 means idle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gap_q <= 4'hF;
            op_q <= mx_exec_pkg::OP_IDLE;
        end else if (instr_c) begin
            gap_q <= 4'h0;
            op_q <= hwdata[20:16];
        end else if (gap_q != 4'hF) begin
            gap_q <= gap_q + 4'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_rdata_stands: assert property (!$past(acc) |-> $stable(hrdata)) else $error("hrdata moved");
    a_halt_sleeps: assert property (
        instr_c && hwdata[20:16] == mx_exec_pkg::OP_HALT && gap_q >= 4'hA && !powerdown |-> ##[1:3] powerdown)
        else $error("halt did not power down");
    a_sleep_cause: assert property ($rose(powerdown) |-> op_q == mx_exec_pkg::OP_HALT)
        else $error("power down without halt");
    a_wake_ctrl: assert property (ctrl_c && hwdata[0] && powerdown |-> ##[1:3] !powerdown)
        else $error("wake ignored");
    a_cycles_count: assert property (
        rd_q && adr_q == mx_exec_pkg::REG_CYCLES |-> hrdata inside {32'h0, 32'h4, 32'h8})
        else $error("bad cycle count");
    a_wreg_byte: assert property (rd_q && adr_q == mx_exec_pkg::REG_WREG |-> hrdata[31:8] == 24'h0)
        else $error("wreg wider than a byte");
    a_unmapped_zero: assert property (rd_q && adr_q > mx_exec_pkg::REG_WDT |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    c_halt: cover property (instr_c && hwdata[20:16] == mx_exec_pkg::OP_HALT);
    c_long: cover property (rd_q && adr_q == mx_exec_pkg::REG_CYCLES && hrdata == 32'h8);
    c_wake: cover property ($fell(powerdown));
endmodule // mx_exec_assertions

bind mx_exec mx_exec_assertions mx_exec_assertions_i (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .powerdown);

/* verification/tb_mx_exec.sv */
/* tb_mx_exec: self-checking bench for mx_exec through its register bus.
   Assumes the master model and the bound checker are compiled alongside. */
`timescale 1ns/1ns
module tb_mx_exec;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, powerdown;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int failures = 0;
    int cmp_count = 0;
    int ticks = 0;
    always #5 core_clk = ~core_clk;
    mx_ahb_host mx_ahb_host_i (.core_clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata);
    mx_exec #(.WIDE_ADDR(1'b1)) mx_exec_i (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .powerdown);
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        ticks++;
        if (ticks == 20000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        mx_ahb_host_i.xfer(a, 1'b1, d, rv);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        mx_ahb_host_i.xfer(a, 1'b0, 32'h0, rv);
        check(nm, rv, exp);
    endtask
    task automatic setm(input logic [7:0] a, input logic [7:0] d);
        wr(mx_exec_pkg::REG_MEM_ADDR, {24'h0, a});
        wr(mx_exec_pkg::REG_MEM_DATA, {24'h0, d});
    endtask
    task automatic chk_m(input logic [7:0] a, input logic [7:0] exp);
        wr(mx_exec_pkg::REG_MEM_ADDR, {24'h0, a});
        rdc("mem", mx_exec_pkg::REG_MEM_DATA, {24'h0, exp});
    endtask
    task automatic chk_ws(input logic [7:0] w, input logic [5:0] s, input logic [7:0] cyc);
        rdc("wreg", mx_exec_pkg::REG_WREG, {24'h0, w});
        rdc("status", mx_exec_pkg::REG_STATUS, {26'h0, s});
        rdc("cycles", mx_exec_pkg::REG_CYCLES, {24'h0, cyc});
    endtask
    task automatic prep(input logic [7:0] w, input logic [3:0] s);
        wr(mx_exec_pkg::REG_WREG, {24'h0, w});
        wr(mx_exec_pkg::REG_STATUS, {28'h0, s});
    endtask
    // polls busy under a bound instead of assuming the instruction length
    task automatic exec(input logic [4:0] op, input logic [7:0] imm, input logic [7:0] a);
        int n;
        wr(mx_exec_pkg::REG_INSTR, {11'h0, op, imm, a});
        n = 0;
        do begin
            mx_ahb_host_i.xfer(mx_exec_pkg::REG_CTRL, 1'b0, 32'h0, rv);
            n++;
        end while (rv[mx_exec_pkg::CT_BUSY] !== 1'b0 && n < 20);
    endtask
    // powerdown trails the halted state by one clock
    task automatic chk_pd(input logic exp);
        @(posedge core_clk);
        @(negedge core_clk);
        check("powerdown", {31'h0, powerdown}, {31'h0, exp});
    endtask
    task automatic t_reset();
        chk_ws(8'h00, 6'h00, 8'h00);
        rdc("pcl", mx_exec_pkg::REG_PCL, 32'h0);
        wr(8'h40, 32'h5A);
        rdc("unmapped", 8'h40, 32'h0);
    endtask
    task automatic t_idle();
        prep(8'h5A, 4'hA);
        setm(8'h30, 8'h77);
        exec(mx_exec_pkg::OP_IDLE, 8'hFF, 8'h30);
        chk_ws(8'h5A, 6'h0A, 8'h04);
        chk_m(8'h30, 8'h77);
    endtask
    task automatic t_add();
        prep(8'h88, 4'h0);
        setm(8'h30, 8'h88);
        exec(mx_exec_pkg::OP_ADD_M, 8'h00, 8'h30);
        chk_m(8'h30, 8'h10);
        chk_ws(8'h88, 6'h0B, 8'h04);
        prep(8'h10, 4'h0);
        exec(mx_exec_pkg::OP_ADD_AX, 8'hF0, 8'h30);
        chk_ws(8'h00, 6'h05, 8'h04);
        exec(mx_exec_pkg::OP_ADC_AM, 8'h00, 8'h30);
        chk_ws(8'h11, 6'h00, 8'h04);
        prep(8'h0F, 4'h1);
        exec(mx_exec_pkg::OP_ADC_M, 8'h00, 8'h30);
        chk_m(8'h30, 8'h20);
        chk_ws(8'h0F, 6'h02, 8'h04);
        prep(8'h7F, 4'h0);
        exec(mx_exec_pkg::OP_ADD_AM, 8'h00, 8'h30);
        chk_ws(8'h9F, 6'h08, 8'h04);
    endtask
    task automatic t_and();
        prep(8'hF0, 4'hB);
        setm(8'h31, 8'h3C);
        exec(mx_exec_pkg::OP_AND_AM, 8'h00, 8'h31);
        chk_ws(8'h30, 6'h0B, 8'h04);
        exec(mx_exec_pkg::OP_AND_AX, 8'h0F, 8'h31);
        chk_ws(8'h00, 6'h0F, 8'h04);
        prep(8'h0F, 4'hB);
        exec(mx_exec_pkg::OP_AND_M, 8'h00, 8'h31);
        chk_m(8'h31, 8'h0C);
        chk_ws(8'h0F, 6'h0B, 8'h04);
    endtask
    task automatic t_misc();
        prep(8'h00, 4'hB);
        setm(8'h32, 8'hA5);
        exec(mx_exec_pkg::OP_SWAP_A, 8'h00, 8'h32);
        chk_ws(8'h5A, 6'h0B, 8'h04);
        exec(mx_exec_pkg::OP_SWAP_M, 8'h00, 8'h32);
        chk_m(8'h32, 8'h5A);
        exec(mx_exec_pkg::OP_CLR_M, 8'h00, 8'h32);
        chk_m(8'h32, 8'h00);
        exec(mx_exec_pkg::OP_SET_M, 8'h00, 8'h32);
        chk_m(8'h32, 8'hFF);
        chk_ws(8'h5A, 6'h0B, 8'h04);
    endtask
    task automatic t_pcl_skip();
        exec(mx_exec_pkg::OP_SET_M, 8'h00, mx_exec_pkg::PCL_MEM_ADDR);
        rdc("cycles", mx_exec_pkg::REG_CYCLES, 32'h8);
        rdc("pcl", mx_exec_pkg::REG_PCL, 32'hFF);
        // 0x86 would fold onto the alias with a 7-bit field
        setm(8'h86, 8'h55);
        exec(mx_exec_pkg::OP_CLR_M, 8'h00, 8'h86);
        rdc("cycles", mx_exec_pkg::REG_CYCLES, 32'h4);
        rdc("pcl", mx_exec_pkg::REG_PCL, 32'hFF);
        chk_m(8'h86, 8'h00);
        setm(8'h33, 8'h00);
        exec(mx_exec_pkg::OP_SKIP_Z, 8'h00, 8'h33);
        rdc("cycles", mx_exec_pkg::REG_CYCLES, 32'h8);
        rdc("ctrl", mx_exec_pkg::REG_CTRL, 32'h4);
        setm(8'h33, 8'h01);
        exec(mx_exec_pkg::OP_SKIP_Z, 8'h00, 8'h33);
        rdc("cycles", mx_exec_pkg::REG_CYCLES, 32'h4);
        rdc("ctrl", mx_exec_pkg::REG_CTRL, 32'h0);
    endtask
    task automatic t_power();
        prep(8'h00, 4'h0);
        exec(mx_exec_pkg::OP_HALT, 8'h00, 8'h00);
        chk_pd(1'b1);
        rdc("status", mx_exec_pkg::REG_STATUS, 32'h10);
        rdc("ctrl", mx_exec_pkg::REG_CTRL, 32'h2);
        wr(mx_exec_pkg::REG_CTRL, 32'h1);
        chk_pd(1'b0);
        exec(mx_exec_pkg::OP_WDT_PRE1, 8'h00, 8'h00);
        rdc("status", mx_exec_pkg::REG_STATUS, 32'h10);
        rdc("ctrl", mx_exec_pkg::REG_CTRL, 32'h8);
        exec(mx_exec_pkg::OP_WDT_PRE2, 8'h00, 8'h00);
        rdc("status", mx_exec_pkg::REG_STATUS, 32'h0);
        exec(mx_exec_pkg::OP_HALT, 8'h00, 8'h00);
        wr(mx_exec_pkg::REG_CTRL, 32'h1);
        repeat (300) @(posedge core_clk);
        exec(mx_exec_pkg::OP_WDT_CLR, 8'h00, 8'h00);
        rdc("status", mx_exec_pkg::REG_STATUS, 32'h0);
        mx_ahb_host_i.xfer(mx_exec_pkg::REG_WDT, 1'b0, 32'h0, rv);
        check("watchdog", {24'h0, rv[7:0]}, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_idle();
        t_add();
        t_and();
        t_misc();
        t_pcl_skip();
        t_power();
        give_verdict();
    end
endmodule // tb_mx_exec
